//--- core/card_id_reader.sv
// expansion card identification reader with register slave
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
// Operation
// - send two-byte word address before each read
// - card memories answer only at 0x54-0x57
// - big-endian values, single byte reads
// - header bytes AA 55 33 EE at zero
// - revision characters A1 at offset four
// - text fields at 6, 38, 42, 58
// - pin count at 74, serial at 76
// - 74 pin words from offset 88
// - rail current limits at 236, 238, 240
// - supply indicator 242, free area from 244
// - pin word top bit used, reserved zero
// - bit six slew, bit five receiver
// - bit four pull direction, three pull disable
// - low three bits select mux mode
// - analog pins carry only usage flag
module card_id_reader (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        card_id_bus_scl_in,
  output logic             card_id_bus_scl_out,
  output logic             card_id_bus_scl_oe,
  input  wire logic        card_id_bus_sda_in,
  output logic             card_id_bus_sda_out,
  output logic             card_id_bus_sda_oe
);
  import card_id_pkg::*;

  typedef enum {SQ_IDLE, SQ_ISSUE, SQ_WAIT} seq_state_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] header_byte(input logic [1:0] pos);
    case (pos)
      2'h0:    header_byte = HDR_B0;
      2'h1:    header_byte = HDR_B1;
      2'h2:    header_byte = HDR_B2;
      default: header_byte = HDR_B3;
    endcase
  endfunction : header_byte

  // step 0 start, 1 device write, 2-3 address, 4 restart, 5 device read, 6 data, 7 stop
  function automatic bus_cmd_type step_cmd(input logic [2:0] stp, input logic [6:0] dev, input logic [7:0] idx);
    bus_cmd_type c;
    c = '{op: OP_BYTE, data: 8'hFF, ack_bit: 1'b1};
    case (stp)
      3'h0, 3'h4: c.op = OP_START;
      3'h1:       c.data = {dev, 1'b0};
      3'h2:       c.data = ADDR_HIGH_BYTE;
      3'h3:       c.data = idx;
      3'h5:       c.data = {dev, 1'b1};
      3'h6:       c.data = 8'hFF;
      default:    c.op = OP_STOP;
    endcase
    step_cmd = c;
  endfunction : step_cmd

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]    record_mem [0:243];
  seq_state_type seq;
  logic [2:0]    step_no;
  logic [7:0]    rec_idx;
  logic          abort;
  logic [1:0]    card_sel;
  logic          busy;
  logic          done;
  logic          identified;
  logic          no_ack;
  logic          header_bad;
  logic [7:0]    view_idx;
  logic [6:0]    pin_sel;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          eng_valid;
  bus_cmd_type   eng_cmd;
  logic          eng_done;
  logic [7:0]    eng_byte;
  logic          eng_ack;

  card_id_bus_engine u_engine (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .cmd_valid (eng_valid),
    .cmd       (eng_cmd),
    .cmd_done  (eng_done),
    .rx_byte   (eng_byte),
    .rx_ack    (eng_ack),
    .scl_in    (card_id_bus_scl_in),
    .sda_in    (card_id_bus_sda_in),
    .scl_oe    (card_id_bus_scl_oe),
    .sda_oe    (card_id_bus_sda_oe)
  );

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  // only the reserved identification range is ever addressed
  wire [6:0]  card_dev   = CARD_ADDR_BASE | {5'h00, card_sel};
  wire        write_go   = aw_held && w_held && !s_axi_bvalid;
  wire        start_req  = write_go && aw_addr == REG_CTRL && w_strb[0] && w_data[0] && !busy;
  // each header byte compared as it arrives
  wire        hdr_miss   = (rec_idx < HDR_LEN) && (eng_byte != header_byte(rec_idx[1:0]));
  wire        last_byte  = (rec_idx == REC_BYTES - 8'h01);
  wire        write_step = (step_no == 3'h1) || (step_no == 3'h2) || (step_no == 3'h3) || (step_no == 3'h5);

  // big-endian pairing of two single-byte locations
  function automatic logic [15:0] be16(input logic [7:0] ofs);
    be16 = {record_mem[ofs], record_mem[ofs + 8'h01]};
  endfunction : be16

  // revision characters checked against the expected pair
  wire        rev_ok     = identified && record_mem[OFS_REVISION] == REV_CHAR0
                           && record_mem[OFS_REVISION + 8'h01] == REV_CHAR1;
  // pin word p sits at the pin area base plus two per pin
  wire [7:0]  pin_ofs    = OFS_PIN_WORDS + {pin_sel, 1'b0};
  wire [15:0] pin_word   = be16(pin_ofs);
  wire        pin_analog = (pin_sel >= FIRST_ANALOG);
  pin_cfg_type pin_cfg;
  // usage from the top bit, reserved bits dropped
  assign pin_cfg.used           = pin_word[15];
  // analog pins report the usage flag alone
  assign pin_cfg.slew_select    = pin_word[6] && !pin_analog;
  assign pin_cfg.rx_enable      = pin_word[5] && !pin_analog;
  assign pin_cfg.pull_direction = pin_word[4] && !pin_analog;
  assign pin_cfg.pull_disable   = pin_word[3] && !pin_analog;
  assign pin_cfg.mux_mode       = pin_analog ? 3'h0 : pin_word[2:0];

  wire [31:0] status_word = {26'h0, rev_ok, header_bad, no_ack, identified, done, busy};
  wire        pin_ok      = pin_sel < PIN_WORDS;
  wire        rd_hit      = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STATUS
                            || s_axi_araddr == REG_PIN_COUNT || s_axi_araddr == REG_CUR_3V3
                            || s_axi_araddr == REG_CUR_5V || s_axi_araddr == REG_CUR_SYS
                            || s_axi_araddr == REG_SUPPLY || s_axi_araddr == REG_REC_INDEX
                            || s_axi_araddr == REG_REC_DATA || s_axi_araddr == REG_PIN_SEL
                            || s_axi_araddr == REG_PIN_INFO;
  // pin count; rail currents; supply indicator
  wire [31:0] rd_word =
      (s_axi_araddr == REG_CTRL)      ? {29'h0, card_sel, 1'b0} :
      (s_axi_araddr == REG_STATUS)    ? status_word :
      (s_axi_araddr == REG_PIN_COUNT) ? {16'h0, be16(OFS_PIN_COUNT)} :
      (s_axi_araddr == REG_CUR_3V3)   ? {16'h0, be16(OFS_CUR_3V3)} :
      (s_axi_araddr == REG_CUR_5V)    ? {16'h0, be16(OFS_CUR_5V)} :
      (s_axi_araddr == REG_CUR_SYS)   ? {16'h0, be16(OFS_CUR_SYS)} :
      (s_axi_araddr == REG_SUPPLY)    ? {16'h0, be16(OFS_SUPPLY)} :
      (s_axi_araddr == REG_REC_INDEX) ? {24'h0, view_idx} :
      // text fields and serial are read byte by byte here
      (s_axi_araddr == REG_REC_DATA)  ? {24'h0, (view_idx < REC_BYTES) ? record_mem[view_idx] : 8'h00} :
      (s_axi_araddr == REG_PIN_SEL)   ? {25'h0, pin_sel} :
      (s_axi_araddr == REG_PIN_INFO && pin_ok) ? {16'h0, pin_cfg.used, 8'h00, pin_cfg.slew_select,
                                                  pin_cfg.rx_enable, pin_cfg.pull_direction,
                                                  pin_cfg.pull_disable, pin_cfg.mux_mode} :
      32'h0000_0000;
  wire        wr_hit  = aw_addr == REG_CTRL || aw_addr == REG_REC_INDEX || aw_addr == REG_PIN_SEL;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      card_sel      <= 2'h0;
      view_idx      <= 8'h00;
      pin_sel       <= 7'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (w_strb[0] && aw_addr == REG_CTRL && !busy) begin
          card_sel <= w_data[2:1];
        end
        if (w_strb[0] && aw_addr == REG_REC_INDEX) begin
          view_idx <= w_data[7:0];
        end
        if (w_strb[0] && aw_addr == REG_PIN_SEL) begin
          pin_sel <= w_data[6:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // record fetch sequencer
  // ----------------------------------------------------------------
  // open-drain data levels are always low; the enables carry the bits
  always_ff @(posedge core_clk) begin
    card_id_bus_scl_out <= 1'b0;
    card_id_bus_sda_out <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (seq == SQ_WAIT && eng_done && step_no == 3'h6) begin
      record_mem[rec_idx] <= eng_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      seq        <= SQ_IDLE;
      step_no    <= 3'h0;
      rec_idx    <= 8'h00;
      abort      <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      identified <= 1'b0;
      no_ack     <= 1'b0;
      header_bad <= 1'b0;
      eng_valid  <= 1'b0;
      eng_cmd    <= '{op: OP_STOP, data: 8'hFF, ack_bit: 1'b1};
    end else begin
      eng_valid <= 1'b0;
      case (seq)
        SQ_IDLE: begin
          if (start_req) begin
            seq        <= SQ_ISSUE;
            step_no    <= 3'h0;
            rec_idx    <= 8'h00;
            abort      <= 1'b0;
            busy       <= 1'b1;
            done       <= 1'b0;
            identified <= 1'b0;
            no_ack     <= 1'b0;
            header_bad <= 1'b0;
          end
        end
        SQ_ISSUE: begin
          // two address bytes precede every single-byte read
          eng_cmd   <= step_cmd(step_no, card_dev, rec_idx);
          eng_valid <= 1'b1;
          seq       <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (eng_done) begin
            seq     <= SQ_ISSUE;
            step_no <= step_no + 3'h1;
            if (write_step && !eng_ack) begin
              no_ack  <= 1'b1;
              abort   <= 1'b1;
              step_no <= 3'h7;
            end
            if (step_no == 3'h6 && hdr_miss) begin
              header_bad <= 1'b1;
              abort      <= 1'b1;
            end
            if (step_no == 3'h7) begin
              step_no <= 3'h0;
              rec_idx <= rec_idx + 8'h01;
              if (abort || last_byte) begin
                seq        <= SQ_IDLE;
                busy       <= 1'b0;
                done       <= 1'b1;
                identified <= !abort;
              end
            end
          end
        end
        default: seq <= SQ_IDLE;
      endcase
    end
  end

endmodule : card_id_reader

//--- core/card_id_pkg.sv
// constants, types and record layout for the expansion card id reader
package card_id_pkg;

  // ----------------------------------------------------------------
  // clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BUS_PERIOD_NS   = 10000;
  localparam int QUARTER_CYCLES  = BUS_PERIOD_NS / CLK_PERIOD_NS / 4;

  // ----------------------------------------------------------------
  // card memory addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] CARD_ADDR_BASE = 7'h54;
  localparam logic [7:0] ADDR_HIGH_BYTE = 8'h00;
  localparam logic [7:0] REC_BYTES      = 8'hF4;

  // ----------------------------------------------------------------
  // record layout
  // ----------------------------------------------------------------
  localparam logic [7:0] HDR_B0         = 8'hAA;
  localparam logic [7:0] HDR_B1         = 8'h55;
  localparam logic [7:0] HDR_B2         = 8'h33;
  localparam logic [7:0] HDR_B3         = 8'hEE;
  localparam logic [7:0] HDR_LEN        = 8'h04;
  localparam logic [7:0] OFS_REVISION   = 8'h04;
  localparam logic [7:0] REV_CHAR0      = 8'h41;
  localparam logic [7:0] REV_CHAR1      = 8'h31;
  localparam logic [7:0] OFS_CARD_NAME  = 8'h06;
  localparam logic [7:0] OFS_HW_VERSION = 8'h26;
  localparam logic [7:0] OFS_MAKER      = 8'h2A;
  localparam logic [7:0] OFS_PART_NUM   = 8'h3A;
  localparam logic [7:0] OFS_PIN_COUNT  = 8'h4A;
  localparam logic [7:0] OFS_SERIAL     = 8'h4C;
  localparam logic [7:0] OFS_PIN_WORDS  = 8'h58;
  localparam logic [6:0] PIN_WORDS      = 7'h4A;
  localparam logic [6:0] FIRST_ANALOG   = 7'h43;
  localparam logic [7:0] OFS_CUR_3V3    = 8'hEC;
  localparam logic [7:0] OFS_CUR_5V     = 8'hEE;
  localparam logic [7:0] OFS_CUR_SYS    = 8'hF0;
  localparam logic [7:0] OFS_SUPPLY     = 8'hF2;
  localparam logic [7:0] OFS_FREE_AREA  = 8'hF4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_PIN_COUNT = 8'h08;
  localparam logic [7:0] REG_CUR_3V3   = 8'h0C;
  localparam logic [7:0] REG_CUR_5V    = 8'h10;
  localparam logic [7:0] REG_CUR_SYS   = 8'h14;
  localparam logic [7:0] REG_SUPPLY    = 8'h18;
  localparam logic [7:0] REG_REC_INDEX = 8'h1C;
  localparam logic [7:0] REG_REC_DATA  = 8'h20;
  localparam logic [7:0] REG_PIN_SEL   = 8'h24;
  localparam logic [7:0] REG_PIN_INFO  = 8'h28;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP} bus_op_type;

  typedef struct packed {
    bus_op_type op;
    logic [7:0] data;
    logic       ack_bit;
  } bus_cmd_type;

  typedef struct packed {
    logic       used;
    logic       slew_select;
    logic       rx_enable;
    logic       pull_direction;
    logic       pull_disable;
    logic [2:0] mux_mode;
  } pin_cfg_type;

endpackage : card_id_pkg

//--- core/card_id_bus_engine.sv
// two-wire bus bit engine: start, stop and nine-bit byte slots
`timescale 1ns/10ps
module card_id_bus_engine (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     cmd_valid,
  input  card_id_pkg::bus_cmd_type      cmd,
  output logic                          cmd_done,
  output logic [7:0]                    rx_byte,
  output logic                          rx_ack,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          scl_oe,
  output logic                          sda_oe
);
  import card_id_pkg::*;

  typedef enum {ST_IDLE, ST_START, ST_BITS, ST_STOP} eng_state_type;

  eng_state_type state;
  logic [5:0]    tick;
  logic [1:0]    quarter;
  logic [3:0]    slot;
  logic [8:0]    tx;
  logic [8:0]    rx;
  logic [1:0]    scl_sync;
  logic [1:0]    sda_sync;

  // ----------------------------------------------------------------
  // quarter timing and clock stretch
  // ----------------------------------------------------------------
  wire quarter_end = (tick == 6'(QUARTER_CYCLES - 1));
  wire stretched   = (state != ST_IDLE) && (quarter == 2'h2) && !scl_sync[1];
  wire step        = quarter_end && !stretched;

  assign rx_byte = rx[8:1];
  assign rx_ack  = ~rx[0];

  always_ff @(posedge core_clk) begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || state == ST_IDLE || step) begin
      tick <= 6'h00;
    end else if (!quarter_end) begin
      tick <= tick + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // bit sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      quarter  <= 2'h0;
      slot     <= 4'h0;
      tx       <= 9'h1FF;
      rx       <= 9'h000;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (state == ST_IDLE) begin
        if (cmd_valid) begin
          quarter <= 2'h0;
          slot    <= 4'h0;
          tx      <= {cmd.data, cmd.ack_bit};
          case (cmd.op)
            OP_START: state <= ST_START;
            OP_BYTE:  state <= ST_BITS;
            OP_STOP:  state <= ST_STOP;
            default:  state <= ST_IDLE;
          endcase
        end
      end else if (step) begin
        quarter <= quarter + 2'h1;
        case (state)
          ST_START: begin
            case (quarter)
              2'h0:    sda_oe <= 1'b0;
              2'h1:    scl_oe <= 1'b0;
              2'h2:    sda_oe <= 1'b1;
              default: scl_oe <= 1'b1;
            endcase
          end
          ST_STOP: begin
            case (quarter)
              2'h0:    sda_oe <= 1'b1;
              2'h1:    scl_oe <= 1'b0;
              2'h2:    sda_oe <= 1'b0;
              default: sda_oe <= 1'b0;
            endcase
          end
          ST_BITS: begin
            case (quarter)
              2'h0:    sda_oe <= ~tx[8];
              2'h1:    scl_oe <= 1'b0;
              2'h2:    rx <= {rx[7:0], sda_sync[1]};
              default: begin
                scl_oe <= 1'b1;
                tx     <= {tx[7:0], 1'b1};
                slot   <= slot + 4'h1;
              end
            endcase
          end
          default: state <= ST_IDLE;
        endcase
        if (quarter == 2'h3 && (state != ST_BITS || slot == 4'h8)) begin
          state    <= ST_IDLE;
          cmd_done <= 1'b1;
        end
      end
    end
  end

endmodule : card_id_bus_engine

//--- dv/card_id_reader_sva.sv
// concurrent checks on the card id reader ports
`timescale 1ns/10ps
module card_id_reader_sva (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        card_id_bus_scl_out,
  input wire logic        card_id_bus_scl_oe,
  input wire logic        card_id_bus_sda_out
);
  import card_id_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  a_write_answer: assert property (wr_go |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_write_refused: assert property (wr_go && s_axi_awaddr > REG_PIN_INFO
    |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR)) else $error("unmapped write accepted");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_read_refused: assert property (rd_go && s_axi_araddr > REG_PIN_INFO
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_open_drain: assert property (!card_id_bus_scl_out && !card_id_bus_sda_out) else $error("line driven high");
  a_clock_quarter: assert property ($changed(card_id_bus_scl_oe) |=> $stable(card_id_bus_scl_oe)[*8])
    else $error("bus clock phase too short");
  a_reset_idle: assert property ($rose(resetn) |-> !s_axi_bvalid && !s_axi_rvalid && !card_id_bus_scl_oe)
    else $error("outputs busy after reset");
  c_write: cover property (wr_go);
  c_bad_read: cover property (rd_go && s_axi_araddr > REG_PIN_INFO);
  c_bus_clock: cover property ($rose(card_id_bus_scl_oe));
endmodule : card_id_reader_sva
bind card_id_reader card_id_reader_sva u_sva (.*);

//--- dv/card_eeprom_model.sv
// behavioural identification memory on the card bus
`timescale 1ns/10ps
module card_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h54
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  // no write path, so no page write to overflow
  logic [7:0]  mem [0:32767];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        rd;
  int          bits;
  int          phase;
  initial begin
    sda_oe = 1'b0;
    phase = 0;
    bits = 0;
  end
  always @(negedge sda) if (scl) begin
    bits = 0;
    phase = 1;
  end
  always @(posedge sda) if (scl) phase = 0;
  always @(posedge scl) if (phase != 0) begin
    if (bits < 8) begin
      sh = {sh[6:0], sda};
      bits++;
    end else if (phase == 4 && sda) phase = 0;
  end
  // own select only, two address bytes, reads run on while the master acks
  always @(negedge scl) if (phase != 0) begin
    if (bits == 8) begin
      if (phase == 1) rd = sh[0];
      if (phase == 1 && sh[7:1] != DEV_ADDR) phase = 0;
      if (phase == 2) ptr[15:8] = sh;
      if (phase == 3) ptr[7:0] = sh;
      sda_oe = (phase != 0 && phase != 4);
      bits = 9;
    end else if (bits == 9) begin
      sda_oe = 1'b0;
      bits = 0;
      if (phase == 4) ptr++;
      phase = ((phase == 1 && rd) || phase == 4) ? 4 : (phase == 3 ? 0 : phase + 1);
    end
    if (phase == 4 && bits < 8) sda_oe = !mem[ptr[14:0]][7 - bits];
  end
endmodule : card_eeprom_model

//--- dv/test_expansion_card_id_reader.sv
// self-checking bench for the card id reader
`timescale 1ns/10ps
module test_expansion_card_id_reader;
  import card_id_pkg::*;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0]  resp, sel;
  logic        core_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  wire         awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, mem_oe;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  // lines stay wired and pulled up when released
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || mem_oe);
  int          bad_count, checks, cyc, k;
  card_id_reader dut (.core_clk, .resetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_id_bus_scl_in(scl),
    .card_id_bus_scl_out(), .card_id_bus_scl_oe(scl_oe), .card_id_bus_sda_in(sda),
    .card_id_bus_sda_out(), .card_id_bus_sda_oe(sda_oe));
  // card model drives only the id bus
  card_eeprom_model #(.DEV_ADDR(CARD_ADDR_BASE)) mem_card (.scl, .sda, .sda_oe(mem_oe));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    {ad, wd} = 2'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    resp = bresp;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
  endtask : axi_read
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_read(a);
    cmp(rd, e);
    cmp(resp, er);
  endtask : rd_chk
  task automatic finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ceiling: four header bytes at about ten thousand cycles each, with margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    {resetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'h3;
    void'($urandom(32'hB6F9));
    k = $urandom % 4;
    sel = 2'h1 + 2'($urandom % 3);
    {mem_card.mem[0], mem_card.mem[1], mem_card.mem[2], mem_card.mem[3]} = {HDR_B0, HDR_B1, HDR_B2, HDR_B3};
    mem_card.mem[k] = mem_card.mem[k] ^ (8'h01 << ($urandom % 8));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk(REG_STATUS, 32'h0, RESP_OKAY);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    axi_write(8'h40, 32'h1);
    cmp(resp, RESP_SLVERR);
    axi_write(REG_PIN_SEL, 32'h4A);
    rd_chk(REG_PIN_INFO, 32'h0, RESP_OKAY);
    axi_write(REG_REC_INDEX, 32'hF4);
    rd_chk(REG_REC_DATA, 32'h0, RESP_OKAY);
    axi_write(REG_CTRL, {29'h0, sel, 1'b1});
    axi_read(REG_STATUS);
    cmp(rd[0], 1'b1);
    axi_write(REG_CTRL, 32'h1);
    cmp(resp, RESP_OKAY);
    rd_chk(REG_CTRL, {29'h0, sel, 1'b0}, RESP_OKAY);
    do axi_read(REG_STATUS); while (rd[0] !== 1'b0);
    cmp(rd[4:2], 3'h2);
    axi_write(REG_CTRL, 32'h1);
    do axi_read(REG_STATUS); while (rd[0] !== 1'b0);
    cmp(rd[4:2], 3'h4);
    cmp(mem_card.ptr, k);
    axi_write(REG_REC_INDEX, k);
    rd_chk(REG_REC_DATA, {24'h0, mem_card.mem[k]}, RESP_OKAY);
    finish_test;
  end
endmodule : test_expansion_card_id_reader
